/* File: src/sls_pkg.sv */
// constants and types for the serial lane link status bank
package sls_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_PAGE = 12'h0300;
  localparam logic [11:0] IDX_LANE4 = 12'h04b4;
  localparam logic [11:0] IDX_LANE5 = 12'h04b5;
  localparam logic [11:0] IDX_THRESH = 12'h04c0;
  localparam logic [11:0] IDX_EVT_STAT = 12'h04c1;
  localparam logic [11:0] IDX_EVT_CLR = 12'h04c2;
  localparam logic [11:0] IDX_EVT_EN = 12'h04c3;
  localparam int AW = 16;
  localparam int DW = 32;
  localparam int IDX_LSB = 2;
  // lanes per link held by this bank
  localparam int LANES = 2;
  // status field positions
  localparam int BIT_CGS = 0;
  localparam int BIT_FS = 1;
  localparam int BIT_CKS = 2;
  localparam int BIT_ILS = 3;
  localparam int BIT_ILD = 4;
  localparam int BIT_UEK = 5;
  localparam int BIT_NIT = 6;
  localparam int BIT_BDE = 7;
  localparam int SYNC_HI = 4;
  localparam int ERR_LO = 5;
  localparam int ERR_HI = 7;
  // event layout: error rise per lane, then sync loss per lane
  localparam int EVT_ERR = 0;
  localparam int EVT_LOSS = 2;
  localparam int EVT_W = 4;
  // reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_THRESH = 8'hff;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [3:0] RST_EVT = 4'h0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // raw per-lane state from the receiver logic
  typedef struct packed {
    logic deskew_ok;
    logic init_sync_ok;
    logic checksum_ok;
    logic frame_sync_ok;
    logic codegroup_sync_ok;
    logic [7:0] disp_cnt;
    logic [7:0] invalid_cnt;
    logic [7:0] unexp_ctrl_cnt;
  } sls_lane_in_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } sls_apb_e;
endpackage

/* File: src/sls_top.sv */
// serial lane link status bank with apb slave and event interrupt
// How it works
// RL1 - bit 4 of each lane status reads 1 when inter-lane deskew succeeded, else 0.
// RL2 - bit 3 reads 1 while initial lane synchronization is achieved, 0 when lost.
// RL3 - bit 2 reads 1 when the lane configuration checksum is correct, 0 otherwise.
// RL4 - bit 1 reads 1 while frame synchronization is held, 0 once lost.
// RL5 - bit 0 reads 1 while code-group synchronization is achieved, 0 when lost.
// RL6 - bit 7 is set when the disparity error count is at or above the threshold.
// RL7 - bit 6 is set when the invalid symbol count is at or above the threshold.
// RL8 - bit 5 is set when the unexpected control count is at or above the threshold.
// RL9 - a lane status read returns the link chosen by the page register at 0x300; a page past the last link reads 0.
// RL10 - status clears to zero at reset and writes to it are ignored.
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
`default_nettype none

module sls_top #(
  parameter int NUM_LINKS = 2
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [sls_pkg::AW-1:0] paddr_in,
  input wire logic [sls_pkg::DW-1:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [sls_pkg::DW-1:0] prdata_out,
  // receiver lane state, same clock, index link*LANES+lane
  input wire sls_pkg::sls_lane_in_s lane_in [NUM_LINKS*sls_pkg::LANES],
  // interrupt
  output logic irq_out
);

  localparam int NK = NUM_LINKS * sls_pkg::LANES;

  generate
    if (NUM_LINKS < 1 || NUM_LINKS > 256) begin : g_bad
      $error("NUM_LINKS must lie in 1..256");
    end
    // paged view and event layout assume two lanes per link
    if (sls_pkg::LANES != 2) begin : g_bad_lanes
      $error("LANES must be 2");
    end
    if (sls_pkg::EVT_W != 2 * sls_pkg::LANES) begin : g_bad_evt
      $error("EVT_W must hold one error and one loss bit per lane");
    end
    // index plus byte offset must fit the bus address with room to spare
    if (sls_pkg::AW < 13 + sls_pkg::IDX_LSB) begin : g_bad_aw
      $error("AW too narrow for the register index");
    end
  endgenerate

  // register index match, used by every decode
  function automatic logic reg_hit(
    input logic [sls_pkg::AW-1:0] addr,
    input logic [11:0] idx
  );
    logic [sls_pkg::AW-1:0] want;
    want = {{(sls_pkg::AW-12-sls_pkg::IDX_LSB){1'b0}}, idx, {sls_pkg::IDX_LSB{1'b0}}};
    return addr == want;
  endfunction

  // error flag test: count at or above the shared threshold, unsigned
  function automatic logic at_limit(
    input logic [7:0] cnt,
    input logic [7:0] thr
  );
    return cnt >= thr;
  endfunction

  sls_pkg::sls_apb_e state_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [sls_pkg::DW-1:0] prdata_ff;
  logic irq_ff;
  logic [7:0] page_ff;
  logic [7:0] thresh_ff;
  logic [sls_pkg::EVT_W-1:0] evt_ff;
  logic [sls_pkg::EVT_W-1:0] evt_en_ff;
  logic [7:0] stat_ff [NK];
  logic [7:0] nxt_stat [NK];
  logic [sls_pkg::EVT_W-1:0] nxt_evt;
  logic [sls_pkg::EVT_W-1:0] evt_set;
  logic [sls_pkg::EVT_W-1:0] evt_clr;
  logic [sls_pkg::DW-1:0] rd_data;
  logic rd_ok;
  logic wr_fire;
  logic [7:0] sel_l4;
  logic [7:0] sel_l5;
  logic wr_page;
  logic wr_thresh;
  logic wr_evt_en;
  logic wr_evt_clr;

  // status snapshot per link and lane
  genvar gk;
  generate
    for (gk = 0; gk < NK; gk++) begin : g_lane
      always_comb begin
        nxt_stat[gk] = sls_pkg::RST_STATUS;
        nxt_stat[gk][sls_pkg::BIT_ILD] = lane_in[gk].deskew_ok; // [RL1]
        nxt_stat[gk][sls_pkg::BIT_ILS] = lane_in[gk].init_sync_ok; // [RL2]
        nxt_stat[gk][sls_pkg::BIT_CKS] = lane_in[gk].checksum_ok; // [RL3]
        nxt_stat[gk][sls_pkg::BIT_FS] = lane_in[gk].frame_sync_ok; // [RL4]
        nxt_stat[gk][sls_pkg::BIT_CGS] = lane_in[gk].codegroup_sync_ok; // [RL5]
        nxt_stat[gk][sls_pkg::BIT_BDE] = at_limit(lane_in[gk].disp_cnt, thresh_ff); // [RL6]
        nxt_stat[gk][sls_pkg::BIT_NIT] = at_limit(lane_in[gk].invalid_cnt, thresh_ff); // [RL7]
        nxt_stat[gk][sls_pkg::BIT_UEK] = at_limit(lane_in[gk].unexp_ctrl_cnt, thresh_ff); // [RL8]
      end

      // status is hardware owned; no bus path reaches it
      always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          stat_ff[gk] <= sls_pkg::RST_STATUS; // [RL10]
        end else begin
          stat_ff[gk] <= nxt_stat[gk];
        end
      end
    end
  endgenerate

  // events: error flags rising from none set, or any sync bit dropping, any link
  always_comb begin
    evt_set = sls_pkg::RST_EVT;
    for (int k = 0; k < NK; k++) begin
      if (|nxt_stat[k][sls_pkg::ERR_HI:sls_pkg::ERR_LO] &&
          !(|stat_ff[k][sls_pkg::ERR_HI:sls_pkg::ERR_LO])) begin
        evt_set[sls_pkg::EVT_ERR + (k % sls_pkg::LANES)] = 1'b1;
      end
      if (|(stat_ff[k][sls_pkg::SYNC_HI:0] & ~nxt_stat[k][sls_pkg::SYNC_HI:0])) begin
        evt_set[sls_pkg::EVT_LOSS + (k % sls_pkg::LANES)] = 1'b1;
      end
    end
  end

  // paged view of the two lanes
  always_comb begin
    sel_l4 = sls_pkg::RST_STATUS;
    sel_l5 = sls_pkg::RST_STATUS;
    for (int l = 0; l < NUM_LINKS; l++) begin
      if (page_ff == l[7:0]) begin
        sel_l4 = stat_ff[l * sls_pkg::LANES]; // [RL9]
        sel_l5 = stat_ff[l * sls_pkg::LANES + 1]; // [RL9]
      end
    end
  end

  // read decode
  always_comb begin
    rd_ok = 1'b1;
    rd_data = sls_pkg::RD_ZERO;
    if (reg_hit(paddr_in, sls_pkg::IDX_LANE4)) begin
      rd_data[7:0] = sel_l4;
    end else if (reg_hit(paddr_in, sls_pkg::IDX_LANE5)) begin
      rd_data[7:0] = sel_l5;
    end else if (reg_hit(paddr_in, sls_pkg::IDX_PAGE)) begin
      rd_data[7:0] = page_ff;
    end else if (reg_hit(paddr_in, sls_pkg::IDX_THRESH)) begin
      rd_data[7:0] = thresh_ff;
    end else if (reg_hit(paddr_in, sls_pkg::IDX_EVT_STAT)) begin
      rd_data[sls_pkg::EVT_W-1:0] = evt_ff;
    end else if (reg_hit(paddr_in, sls_pkg::IDX_EVT_EN)) begin
      rd_data[sls_pkg::EVT_W-1:0] = evt_en_ff;
    end else if (reg_hit(paddr_in, sls_pkg::IDX_EVT_CLR)) begin
      rd_data = sls_pkg::RD_ZERO;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // apb handshake: one wait-free access cycle after setup
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_ff <= sls_pkg::ST_IDLE;
      pready_ff <= 1'b0;
    end else begin
      case (state_ff)
        sls_pkg::ST_IDLE: begin
          if (psel_in && !penable_in) begin
            state_ff <= sls_pkg::ST_ACCESS;
            pready_ff <= 1'b1;
          end
        end
        sls_pkg::ST_ACCESS: begin
          state_ff <= sls_pkg::ST_IDLE;
          pready_ff <= 1'b0;
        end
        default: begin
          state_ff <= sls_pkg::ST_IDLE;
          pready_ff <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prdata_ff <= sls_pkg::RD_ZERO;
      pslverr_ff <= 1'b0;
    end else if (state_ff == sls_pkg::ST_IDLE && psel_in && !penable_in) begin
      prdata_ff <= pwrite_in ? sls_pkg::RD_ZERO : rd_data;
      pslverr_ff <= !rd_ok;
    end else begin
      prdata_ff <= sls_pkg::RD_ZERO;
      pslverr_ff <= 1'b0;
    end
  end

  // write commits at the completing access edge only
  assign wr_fire = (state_ff == sls_pkg::ST_ACCESS) && psel_in && penable_in &&
                   pwrite_in && pstrb_in[0];

  // one decode per writable register; status registers have none
  assign wr_page = wr_fire && reg_hit(paddr_in, sls_pkg::IDX_PAGE);
  assign wr_thresh = wr_fire && reg_hit(paddr_in, sls_pkg::IDX_THRESH);
  assign wr_evt_en = wr_fire && reg_hit(paddr_in, sls_pkg::IDX_EVT_EN);
  assign wr_evt_clr = wr_fire && reg_hit(paddr_in, sls_pkg::IDX_EVT_CLR);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      page_ff <= sls_pkg::RST_PAGE;
    end else if (wr_page) begin
      page_ff <= pwdata_in[7:0]; // [RL9]
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      thresh_ff <= sls_pkg::RST_THRESH;
    end else if (wr_thresh) begin
      thresh_ff <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      evt_en_ff <= sls_pkg::RST_EVT;
    end else if (wr_evt_en) begin
      evt_en_ff <= pwdata_in[sls_pkg::EVT_W-1:0];
    end
  end

  // clear takes ones; a fresh event in the same cycle survives
  always_comb begin
    evt_clr = sls_pkg::RST_EVT;
    if (wr_evt_clr) begin
      evt_clr = pwdata_in[sls_pkg::EVT_W-1:0];
    end
    nxt_evt = (evt_ff & ~evt_clr) | evt_set;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      evt_ff <= sls_pkg::RST_EVT;
    end else begin
      evt_ff <= nxt_evt;
    end
  end

  // registered so the line is glitch free
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_evt & evt_en_ff);
    end
  end

  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign prdata_out = prdata_ff;
  assign irq_out = irq_ff;

endmodule

`default_nettype wire

/* File: test/sls_properties.sv */
// assertions on apb timing, lane status reads and interrupt masking
`timescale 1ns/1ns
`default_nettype none
module sls_properties #(parameter int NUM_LINKS = 2) (
  // watched ports
  input wire logic clk_in, sys_rst_in, psel_in, penable_in, pwrite_in,
  input wire logic pready_out, pslverr_out, irq_out,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in, prdata_out,
  input wire logic [3:0] pstrb_in,
  input wire sls_pkg::sls_lane_in_s lane_in [NUM_LINKS*sls_pkg::LANES]
);
  logic [7:0] pg_ff;
  wire logic setup = psel_in && !penable_in;
  wire logic done = psel_in && penable_in && pready_out;
  // page mirror, so lane reads can be predicted
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      pg_ff <= 8'h00;
    else if (done && pwrite_in && pstrb_in[0] && paddr_in == 16'h0c00)
      pg_ff <= pwdata_in[7:0];
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  chk_ready_once: assert property (pready_out |=> !pready_out)
    else $error("pready held");
  chk_ready_next: assert property (setup |=> pready_out)
    else $error("no pready");
  chk_err_nodata: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0000_0000)
    else $error("error with data");
  chk_idle_quiet: assert property (!pready_out |-> !pslverr_out && prdata_out == 32'h0000_0000)
    else $error("idle bus not quiet");
  chk_unmapped_err: assert property (setup && paddr_in[15:13] != 3'h0 |=> pslverr_out)
    else $error("unmapped accepted");
  chk_status_ok: assert property (setup && paddr_in == 16'h12d0 |=> !pslverr_out)
    else $error("status refused");
  chk_lane_sync: assert property (
    setup && !pwrite_in && paddr_in == 16'h12d0 && pg_ff == 8'h00
    |=> prdata_out[4:0] == $past(lane_in[0][28:24], 2))
    else $error("lane sync bits wrong");
  chk_irq_masked: assert property (done && pwrite_in && pstrb_in[0] && paddr_in == 16'h130c
    && pwdata_in[3:0] == 4'h0 |-> ##2 !irq_out)
    else $error("masked irq high");
  cover property (done && !pwrite_in && paddr_in == 16'h12d0);
  cover property (pslverr_out);
  cover property ($rose(irq_out));
endmodule
`default_nettype wire

/* File: test/sls_lane_model.sv */
// far-end receiver front: presents commanded lane state
`timescale 1ns/1ns
`default_nettype none
module sls_lane_model #(parameter int N = 4) (
  input wire logic clk_in,
  input wire sls_pkg::sls_lane_in_s cmd_in [N],
  output var sls_pkg::sls_lane_in_s lane_out [N]
);
  // registered, like a real receiver stage
  always_ff @(posedge clk_in) begin
    lane_out <= cmd_in;
  end
endmodule
`default_nettype wire

/* File: test/sls_top_bench.sv */
// self-checking bench for the lane status bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module sls_top_bench;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, ex;
  logic [3:0] pstrb = 4'h1;
  logic pready, pslverr, irq, err;
  logic [7:0] thr, pg;
  integer seed = 32'hafa541d2;
  int num_errors = 0, total_checks = 0;
  sls_pkg::sls_lane_in_s cmd [4] = '{default: '0};
  sls_pkg::sls_lane_in_s lane [4];
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  sls_lane_model i_sls_lane_model (.clk_in(clk_in), .cmd_in(cmd), .lane_out(lane));
  sls_top i_sls_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
    .lane_in(lane), .irq_out(irq));
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      num_errors++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    `CHK(rd, exp)
    `CHK(err, 1'b0)
  endtask
  function automatic logic [31:0] exp_st(input sls_pkg::sls_lane_in_s l, input logic [7:0] t);
    return {24'h00_0000, l.disp_cnt >= t, l.invalid_cnt >= t, l.unexp_ctrl_cnt >= t, l[28:24]};
  endfunction
  // counts straddle the threshold so the equal case comes up often
  function automatic sls_pkg::sls_lane_in_s rl(input logic [7:0] t);
    sls_pkg::sls_lane_in_s s;
    s = 29'($random(seed));
    s.disp_cnt = 8'(t + {$random(seed)} % 3 - 1);
    s.invalid_cnt = 8'(t + {$random(seed)} % 3 - 1);
    s.unexp_ctrl_cnt = 8'(t + {$random(seed)} % 3 - 1);
    return s;
  endfunction
  initial begin
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rdchk(sls_pkg::IDX_LANE4, 32'h0000_0000);
    rdchk(sls_pkg::IDX_LANE5, 32'h0000_0000);
    rdchk(sls_pkg::IDX_THRESH, 32'h0000_00ff);
    apb(1'b0, 12'hfff, 32'h0000_0000);
    `CHK(err, 1'b1)
    for (int k = 0; k < 24; k++) begin
      thr = (k < 2) ? 8'(-k) : 8'($random(seed));
      pg = 8'({$random(seed)} % 3);
      foreach (cmd[i]) cmd[i] <= rl(thr);
      apb(1'b1, sls_pkg::IDX_THRESH, {24'h00_0000, thr});
      apb(1'b1, sls_pkg::IDX_PAGE, {24'h00_0000, pg});
      apb(1'b1, sls_pkg::IDX_LANE5, 32'hffff_ffff);
      for (int j = 0; j < 2; j++) begin
        ex = (pg > 8'h01) ? 32'h0000_0000 : exp_st(cmd[2 * pg + j], thr);
        rdchk(12'(sls_pkg::IDX_LANE4 + j), ex);
      end
    end
    // interrupt raised by a new error flag, then masked and cleared
    foreach (cmd[i]) cmd[i] <= '0;
    apb(1'b1, sls_pkg::IDX_THRESH, 32'h0000_0080);
    apb(1'b1, sls_pkg::IDX_EVT_EN, 32'h0000_000f);
    apb(1'b1, sls_pkg::IDX_EVT_CLR, 32'h0000_000f);
    rdchk(sls_pkg::IDX_EVT_STAT, 32'h0000_0000);
    cmd[0].disp_cnt <= 8'hff;
    repeat (3) @(posedge clk_in);
    `CHK(irq, 1'b1)
    rdchk(sls_pkg::IDX_EVT_STAT, 32'h0000_0001);
    apb(1'b1, sls_pkg::IDX_EVT_EN, 32'h0000_0000);
    repeat (2) @(posedge clk_in);
    `CHK(irq, 1'b0)
    apb(1'b1, sls_pkg::IDX_EVT_CLR, 32'h0000_000f);
    rdchk(sls_pkg::IDX_EVT_STAT, 32'h0000_0000);
    // mid-run reset with error flags up: only a cleared status lets them rise again
    foreach (cmd[i]) cmd[i] <= {5'h1f, 8'hff, 16'h0000};
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rdchk(sls_pkg::IDX_EVT_STAT, 32'h0000_0003);
    rdchk(sls_pkg::IDX_LANE4, exp_st(cmd[0], sls_pkg::RST_THRESH));
    // lane 5 of link 0 dropping its sync bits raises the loss event
    cmd[1] <= '0;
    repeat (2) @(posedge clk_in);
    rdchk(sls_pkg::IDX_EVT_STAT, 32'h0000_000b);
    give_verdict();
  end
endmodule
bind sls_top sls_properties #(.NUM_LINKS(NUM_LINKS)) i_sls_properties (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pstrb_in(pstrb_in), .lane_in(lane_in));
`default_nettype wire
